// File: pssc_power_save_state_control.v
// Power-save state controller: search bound, week grid, pin force and wake
`timescale 1ns/1ps
`include "pssc_map.vh"
module pssc_power_save_state_control
(
  input wire clk,
  input wire rst_n,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output reg [31:0] regRdData,
  input wire extCtrlPinA,
  input wire extCtrlPinB,
  input wire serialRx,
  input wire resetPinLow,
  input wire fixValid,
  input wire needMoreTime,
  input wire timeValid,
  input wire [31:0] weekTimeMs,
  input wire usbAttached,
  input wire predictionBusy,
  input wire rxByteValid,
  input wire [7:0] rxByte,
  output reg searchActive,
  output reg trackingActive,
  output reg optTrackingActive,
  output reg inactive,
  output reg lowestPower,
  output reg orbitRefresh
);
  localparam [5:0] ST_SEARCH = 6'h01;
  localparam [5:0] ST_TRACK = 6'h02;
  localparam [5:0] ST_OPT = 6'h04;
  localparam [5:0] ST_WAIT_SEARCH = 6'h08;
  localparam [5:0] ST_WAIT_FIX = 6'h10;
  localparam [5:0] ST_CFG_READ = 6'h20;
  localparam [31:0] TICK_FULL = `PSSC_TICK_CYC - 1;
  localparam [14:0] TICK_LAST = TICK_FULL[14:0];
  // Idle pin levels, so leaving reset shows no false wake edge
  localparam [3:0] PIN_IDLE = `PSSC_PIN_IDLE;

  reg [6:0] ctrl;
  reg [31:0] fixInterval;
  reg [31:0] retryInterval;
  reg [31:0] minSearch;
  reg [31:0] maxSearch;
  reg [31:0] holdTime;
  reg [31:0] scheduleOffset;
  reg [5:0] state;
  reg [5:0] next_state;
  reg [31:0] stateMs;
  reg [31:0] freeMs;
  reg [31:0] dueMs;
  reg [31:0] refreshMs;
  reg [14:0] tickCnt;
  reg msTick;
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [3:0] prevLvl;
  reg [3:0] stable;
  reg setDue;
  reg [31:0] next_due;

  wire pinLevel;
  wire [3:0] edgeSeen;
  wire wakeEdge;
  wire byteWake;
  wire cyclic;
  wire forceOn;
  wire forceOff;
  wire [31:0] nowMs;
  wire [31:0] maxLimit;
  wire searchFail;
  wire dueHit;

  // Next grid point after now, for period p with grid offset
  function [31:0] pssc_next_grid;
    input [31:0] now;
    input [31:0] per;
    input [31:0] offs;
    reg [31:0] rel;
    begin
      rel = now - offs;
      if (per == 32'h00000000)
        pssc_next_grid = now;
      else
        pssc_next_grid = now + (per - (rel % per));
    end
  endfunction

  // Two flops on every pin before any logic
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1 <= PIN_IDLE;
      sync2 <= PIN_IDLE;
    end
    else
    begin
      sync1 <= {resetPinLow, serialRx, extCtrlPinB, extCtrlPinA};
      sync2 <= sync1;
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      tickCnt <= 15'h0000;
      msTick <= 1'b0;
      freeMs <= 32'h00000000;
    end
    else
    begin
      msTick <= (tickCnt == TICK_LAST);
      tickCnt <= (tickCnt == TICK_LAST) ? 15'h0000 : tickCnt + 15'h0001;
      if (msTick)
        freeMs <= freeMs + 32'h00000001;
    end
  end

  // With USB attached a level counts only at a ms tick, and only if it matched the cycle before
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gFilt
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          prevLvl[gi] <= PIN_IDLE[gi];
          stable[gi] <= PIN_IDLE[gi];
        end
        else if (!usbAttached)
        begin
          prevLvl[gi] <= sync2[gi];
          stable[gi] <= sync2[gi];
        end
        else
        begin
          if (sync2[gi] == prevLvl[gi] && msTick)
            stable[gi] <= prevLvl[gi];
          prevLvl[gi] <= sync2[gi];
        end
      end
    end
  endgenerate

  reg [3:0] stableD;
  always @(posedge clk)
  begin
    if (!rst_n)
      stableD <= PIN_IDLE;
    else
      stableD <= stable;
  end
  assign edgeSeen = stable ^ stableD;
  // Pin edges either way, reset pin only on its rise
  assign wakeEdge = edgeSeen[0] | edgeSeen[1] | edgeSeen[2] |
    (edgeSeen[3] & stable[3]);
  assign byteWake = rxByteValid && (rxByte == `PSSC_WAKE_BYTE);
  assign pinLevel = ctrl[`PSSC_CTRL_PINSEL] ? stable[1] : stable[0];
  assign cyclic = ctrl[`PSSC_CTRL_CYCLIC];
  assign forceOn = ctrl[`PSSC_CTRL_FON] && pinLevel;
  assign forceOff = ctrl[`PSSC_CTRL_FOFF] && !pinLevel;
  // Unaligned free count until valid time is known
  assign nowMs = timeValid ? weekTimeMs : freeMs;
  assign maxLimit = (maxSearch == 32'h00000000) ? `PSSC_AUTO_MAX_MS : maxSearch;
  assign searchFail = (stateMs >= maxLimit) && (stateMs >= minSearch) && !needMoreTime;
  assign dueHit = (nowMs == dueMs) || (dueMs >= `PSSC_WEEK_MS && nowMs == 32'h00000000);

  always @*
  begin
    next_state = state;
    setDue = 1'b0;
    next_due = dueMs;
    case (state)
      ST_SEARCH:
      begin
        if (fixValid && stateMs >= minSearch)
          next_state = ST_TRACK;
        else if (forceOff && !forceOn)
          next_state = ST_WAIT_SEARCH;
        else if (searchFail && !ctrl[`PSSC_CTRL_STAY] && !forceOn)
        begin
          next_state = ST_WAIT_SEARCH;
          setDue = 1'b1;
          next_due = pssc_next_grid(nowMs, retryInterval,
            cyclic ? 32'h00000000 : scheduleOffset);
        end
      end
      ST_TRACK:
      begin
        if (forceOff && !forceOn)
          next_state = ST_WAIT_FIX;
        else if (stateMs >= holdTime)
        begin
          if (cyclic)
            next_state = ST_OPT;
          else if (!forceOn && !predictionBusy)
          begin
            next_state = ST_WAIT_FIX;
            setDue = 1'b1;
            next_due = pssc_next_grid(nowMs, fixInterval, scheduleOffset);
          end
        end
      end
      ST_OPT:
      begin
        if (!fixValid)
          next_state = ST_SEARCH;
      end
      ST_WAIT_SEARCH, ST_WAIT_FIX:
      begin
        if (forceOn || (ctrl[`PSSC_CTRL_FON] && ctrl[`PSSC_CTRL_FOFF] && pinLevel))
          next_state = ST_SEARCH;
        else if (wakeEdge || byteWake)
          next_state = forceOff ? ST_CFG_READ : ST_SEARCH;
        else if (!forceOff && dueHit)
          next_state = ST_SEARCH;
      end
      ST_CFG_READ:
      begin
        if (stateMs >= `PSSC_CFG_READ_MS)
          next_state = forceOff ? ST_WAIT_SEARCH : ST_SEARCH;
      end
      default:
        next_state = ST_SEARCH;
    endcase
    if (!ctrl[`PSSC_CTRL_ENABLE])
      next_state = ST_SEARCH;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= ST_SEARCH;
      stateMs <= 32'h00000000;
      dueMs <= `PSSC_FIX_RESET;
    end
    else
    begin
      state <= next_state;
      if (next_state != state)
        stateMs <= 32'h00000000;
      else if (msTick)
        stateMs <= stateMs + 32'h00000001;
      if (setDue)
        dueMs <= next_due;
    end
  end

  // Orbit refresh pulse every 30 minutes when enabled
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      refreshMs <= 32'h00000000;
      orbitRefresh <= 1'b0;
    end
    else
    begin
      orbitRefresh <= 1'b0;
      if (!ctrl[`PSSC_CTRL_REFRESH])
        refreshMs <= 32'h00000000;
      else if (msTick)
      begin
        if (refreshMs >= `PSSC_REFRESH_MS - 1)
        begin
          refreshMs <= 32'h00000000;
          orbitRefresh <= 1'b1;
        end
        else
          refreshMs <= refreshMs + 32'h00000001;
      end
    end
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      searchActive <= 1'b1;
      trackingActive <= 1'b0;
      optTrackingActive <= 1'b0;
      inactive <= 1'b0;
      lowestPower <= 1'b0;
    end
    else
    begin
      searchActive <= (next_state == ST_SEARCH) || (next_state == ST_CFG_READ);
      trackingActive <= (next_state == ST_TRACK);
      optTrackingActive <= (next_state == ST_OPT);
      inactive <= (next_state == ST_WAIT_SEARCH) || (next_state == ST_WAIT_FIX);
      lowestPower <= ((next_state == ST_WAIT_SEARCH) || (next_state == ST_WAIT_FIX))
        && !usbAttached;
    end
  end

  // Register port; reads answer one cycle later
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl <= `PSSC_CTRL_RESET;
      fixInterval <= 32'h00000000;
      retryInterval <= 32'h00000000;
      minSearch <= 32'h00000000;
      maxSearch <= 32'h00000000;
      holdTime <= 32'h00000000;
      scheduleOffset <= 32'h00000000;
      regRdData <= 32'h00000000;
    end
    else
    begin
      if (regWr)
      begin
        case (regAddr)
          `PSSC_ADDR_CTRL: ctrl <= regWrData[6:0];
          // Periods beyond one week keep the old value
          `PSSC_ADDR_FIX: if (regWrData <= `PSSC_WEEK_MS) fixInterval <= regWrData;
          `PSSC_ADDR_RETRY: if (regWrData <= `PSSC_WEEK_MS) retryInterval <= regWrData;
          `PSSC_ADDR_MINS: minSearch <= regWrData;
          `PSSC_ADDR_MAXS: maxSearch <= regWrData;
          `PSSC_ADDR_HOLD: holdTime <= regWrData;
          `PSSC_ADDR_OFFS: scheduleOffset <= regWrData;
          default: ;
        endcase
      end
      if (regRd)
      begin
        case (regAddr)
          `PSSC_ADDR_CTRL: regRdData <= {25'h0000000, ctrl};
          `PSSC_ADDR_FIX: regRdData <= fixInterval;
          `PSSC_ADDR_RETRY: regRdData <= retryInterval;
          `PSSC_ADDR_MINS: regRdData <= minSearch;
          `PSSC_ADDR_MAXS: regRdData <= maxSearch;
          `PSSC_ADDR_HOLD: regRdData <= holdTime;
          `PSSC_ADDR_OFFS: regRdData <= scheduleOffset;
          `PSSC_ADDR_STAT: regRdData <= {22'h000000, stable, state};
          `PSSC_ADDR_TIME: regRdData <= dueMs;
          default: regRdData <= 32'h00000000;
        endcase
      end
      else
        regRdData <= 32'h00000000;
    end
  end
endmodule

// File: pssc_map.vh
// Constants for the power-save state controller
`ifndef PSSC_MAP_VH
`define PSSC_MAP_VH
`define PSSC_CLK_HZ 25000000
`define PSSC_TICK_MS 1
`define PSSC_TICK_CYC ((`PSSC_CLK_HZ / 1000) * `PSSC_TICK_MS)
`define PSSC_AUTO_MAX_MS 32'h0000EA60
`define PSSC_REFRESH_MIN 30
`define PSSC_REFRESH_MS (`PSSC_REFRESH_MIN * 60 * 1000)
`define PSSC_WEEK_MS 32'h240C8400
`define PSSC_PRED_MAX_S 20
`define PSSC_PRED_MAX_MS (`PSSC_PRED_MAX_S * 1000)
`define PSSC_CFG_READ_MS 2
`define PSSC_USB_FILT_MS 1
`define PSSC_WAKE_BYTE 8'hFF
`define PSSC_PIN_IDLE 4'hC
`define PSSC_ADDR_CTRL 4'h0
`define PSSC_ADDR_FIX 4'h1
`define PSSC_ADDR_RETRY 4'h2
`define PSSC_ADDR_MINS 4'h3
`define PSSC_ADDR_MAXS 4'h4
`define PSSC_ADDR_HOLD 4'h5
`define PSSC_ADDR_OFFS 4'h6
`define PSSC_ADDR_STAT 4'h7
`define PSSC_ADDR_TIME 4'h8
`define PSSC_CTRL_ENABLE 0
`define PSSC_CTRL_CYCLIC 1
`define PSSC_CTRL_STAY 2
`define PSSC_CTRL_REFRESH 3
`define PSSC_CTRL_PINSEL 4
`define PSSC_CTRL_FON 5
`define PSSC_CTRL_FOFF 6
`define PSSC_CTRL_RESET 7'h00
`define PSSC_FIX_RESET 32'h00000000
`endif

// File: pssc_monitor.sv
// Checker for the power-save state controller, bound to its top module
`timescale 1ns/1ps
`include "pssc_map.vh"
module pssc_monitor
(
  input wire clk,
  input wire rst_n,
  input wire [3:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  input wire [31:0] regRdData,
  input wire extCtrlPinA,
  input wire extCtrlPinB,
  input wire usbAttached,
  input wire rxByteValid,
  input wire [7:0] rxByte,
  input wire searchActive,
  input wire trackingActive,
  input wire optTrackingActive,
  input wire inactive,
  input wire lowestPower,
  input wire orbitRefresh
);
  // Shadow of the control word, rebuilt from bus writes
  reg [6:0] ctrl;
  wire selPin;
  wire fon;
  wire foffOnly;
  assign selPin = ctrl[`PSSC_CTRL_PINSEL] ? extCtrlPinB : extCtrlPinA;
  assign fon = ctrl[`PSSC_CTRL_ENABLE] && ctrl[`PSSC_CTRL_FON];
  assign foffOnly = ctrl[`PSSC_CTRL_ENABLE] && ctrl[`PSSC_CTRL_FOFF] && !ctrl[`PSSC_CTRL_FON];
  always @(posedge clk)
  begin
    if (!rst_n)
      ctrl <= 7'h00;
    else if (regWr && regAddr == `PSSC_ADDR_CTRL)
      ctrl <= regWrData[6:0];
  end
  // A forced-off device may search only for its brief config read
  reg [16:0] offSearch;
  always @(posedge clk)
  begin
    if (!rst_n)
      offSearch <= 17'h00000;
    else if (foffOnly && !selPin && searchActive)
      offSearch <= offSearch + 17'h00001;
    else
      offSearch <= 17'h00000;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Six cycles cover the two-flop synchroniser and the config latency
  a_force_on_hold: assert property (
    (fon && selPin && !usbAttached) [*6] |-> !inactive)
    else $error("inactive while force-on pin is high");
  a_force_off_low: assert property (
    (foffOnly && !selPin && !usbAttached) [*8] |-> !trackingActive && !optTrackingActive)
    else $error("tracking while force-off pin is low");
  a_offline_read_short: assert property (
    offSearch < ((`PSSC_CFG_READ_MS + 1) * `PSSC_TICK_CYC))
    else $error("search too long while force-off pin is low");
  a_usb_no_lowest: assert property (usbAttached && $past(usbAttached) |-> !lowestPower)
    else $error("lowest power with usb attached");
  a_lowest_when_idle: assert property (
    inactive && $past(inactive) && !usbAttached && !$past(usbAttached) |-> lowestPower)
    else $error("no lowest power while inactive");
  a_refresh_one_cycle: assert property (orbitRefresh |=> !orbitRefresh)
    else $error("refresh pulse longer than one cycle");
  a_wake_byte_search: assert property (
    rxByteValid && rxByte == 8'hFF && inactive && !ctrl[`PSSC_CTRL_FOFF] && !usbAttached
    |-> ##[1:8] searchActive)
    else $error("wake byte did not start a search");
  a_state_exclusive: assert property (
    !(inactive && (searchActive || trackingActive || optTrackingActive)))
    else $error("inactive together with an active state");
  a_ctrl_readback: assert property (
    regRd && regAddr == `PSSC_ADDR_CTRL |=> regRdData[6:0] == $past(ctrl))
    else $error("control read differs from last write");
  cover property ($rose(inactive));
  cover property ($past(inactive) && searchActive);
  cover property (lowestPower);
endmodule
bind pssc_power_save_state_control pssc_monitor mon (.clk, .rst_n, .regAddr, .regWrData, .regWr,
  .regRd, .regRdData, .extCtrlPinA, .extCtrlPinB, .usbAttached, .rxByteValid, .rxByte,
  .searchActive, .trackingActive, .optTrackingActive, .inactive, .lowestPower, .orbitRefresh);

// File: pssc_host_model.sv
// Host controller model: wake pins, reset pin and serial wake byte
`timescale 1ns/1ps
module pssc_host_model
(
  input wire clk,
  output reg pinA,
  output reg pinB,
  output reg serialRx,
  output reg resetPinLow,
  output reg rxByteValid,
  output reg [7:0] rxByte
);
  initial
  begin
    pinA = 1'b0;
    pinB = 1'b0;
    serialRx = 1'b1;
    resetPinLow = 1'b1;
    rxByteValid = 1'b0;
    rxByte = 8'h00;
  end
  // Level stands until changed: high asks for a fix, low for sleep
  task setPin(input sel, input lvl);
    begin
      @(posedge clk);
      if (sel)
        pinB <= lvl;
      else
        pinA <= lvl;
    end
  endtask
  // Decoded byte alone, as when the line edges went unseen
  task sendByte(input [7:0] v);
    begin
      @(posedge clk);
      rxByte <= v;
      rxByteValid <= 1'b1;
      @(posedge clk);
      rxByteValid <= 1'b0;
      rxByte <= 8'h00;
    end
  endtask
  // Start bit then ones: the line edges come before the byte strobe
  task sendWake;
    begin
      @(posedge clk);
      serialRx <= 1'b0;
      repeat (10) @(posedge clk);
      serialRx <= 1'b1;
      repeat (79) @(posedge clk);
      sendByte(8'hFF);
    end
  endtask
  task pulseReset;
    begin
      @(posedge clk);
      resetPinLow <= 1'b0;
      repeat (10) @(posedge clk);
      resetPinLow <= 1'b1;
    end
  endtask
endmodule

// File: pssc_tb.sv
// Self-checking bench for the power-save state controller
`timescale 1ns/1ps
`include "pssc_map.vh"
module tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] regAddr = 4'h0;
  reg [31:0] regWrData = 32'h0;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg fixValid = 1'b0;
  reg needMoreTime = 1'b0;
  reg timeValid = 1'b0;
  reg [31:0] weekTimeMs = 32'h0;
  reg usbAttached = 1'b0;
  reg predictionBusy = 1'b0;
  wire extCtrlPinA, extCtrlPinB, serialRx, resetPinLow, rxByteValid;
  wire [7:0] rxByte;
  wire [31:0] regRdData;
  wire searchActive, trackingActive, optTrackingActive, inactive, lowestPower, orbitRefresh;
  wire [5:0] sv;
  integer nMismatch = 0;
  integer testsRun = 0;
  integer i;
  reg [31:0] d;
  assign sv = {orbitRefresh, lowestPower, inactive, optTrackingActive, trackingActive, searchActive};
  always #20 clk = ~clk;
  pssc_host_model host (.clk, .pinA(extCtrlPinA), .pinB(extCtrlPinB), .serialRx, .resetPinLow,
    .rxByteValid, .rxByte);
  pssc_power_save_state_control dut (.clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .extCtrlPinA, .extCtrlPinB, .serialRx, .resetPinLow, .fixValid, .needMoreTime,
    .timeValid, .weekTimeMs, .usbAttached, .predictionBusy, .rxByteValid, .rxByte,
    .searchActive, .trackingActive, .optTrackingActive, .inactive, .lowestPower, .orbitRefresh);
  task check(input [31:0] seen, input [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (seen !== exp)
      begin
        nMismatch = nMismatch + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wrReg(input [3:0] a, input [31:0] v);
    begin
      @(posedge clk);
      regAddr <= a;
      regWrData <= v;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe edge
  task rdReg(input [3:0] a, output [31:0] v);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 v = regRdData;
    end
  endtask
  task resetAndRegs;
    begin
      check({26'h0, sv}, 32'h01);
      rdReg(`PSSC_ADDR_CTRL, d);
      check(d, {25'h0, `PSSC_CTRL_RESET});
      rdReg(4'hF, d);
      check(d, 32'h0);
      wrReg(`PSSC_ADDR_RETRY, `PSSC_WEEK_MS + 32'h1);
      rdReg(`PSSC_ADDR_RETRY, d);
      check(d, 32'h0);
      wrReg(`PSSC_ADDR_RETRY, `PSSC_WEEK_MS);
      rdReg(`PSSC_ADDR_RETRY, d);
      check(d, `PSSC_WEEK_MS);
      // A 45 s search limit, the floor a host should keep
      wrReg(`PSSC_ADDR_MAXS, 32'h0000AFC8);
      rdReg(`PSSC_ADDR_MAXS, d);
      check(d, 32'h0000AFC8);
    end
  endtask
  task forceOnThenRelease;
    begin
      // Short limit only to keep the run short
      wrReg(`PSSC_ADDR_MAXS, 32'h1);
      host.setPin(1'b0, 1'b1);
      wrReg(`PSSC_ADDR_CTRL, 32'h21);
      // Twice the search limit, so only the pin can keep it searching
      repeat (50000) @(posedge clk);
      #1 check({26'h0, sv}, 32'h01);
      host.setPin(1'b0, 1'b0);
      i = 0;
      while (inactive !== 1'b1 && i < 30000)
      begin
        @(posedge clk);
        #1 i = i + 1;
      end
      repeat (2) @(posedge clk);
      #1 check({26'h0, sv}, 32'h18);
      rdReg(`PSSC_ADDR_STAT, d);
      check({26'h0, d[5:0]}, 32'h08);
      @(posedge clk);
      usbAttached <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check({26'h0, sv}, 32'h08);
      @(posedge clk);
      usbAttached <= 1'b0;
    end
  endtask
  task wakeByByte;
    begin
      host.sendByte(`PSSC_WAKE_BYTE);
      repeat (4) @(posedge clk);
      #1 check({26'h0, sv}, 32'h01);
      host.sendWake;
      repeat (8) @(posedge clk);
      rdReg(`PSSC_ADDR_STAT, d);
      check({26'h0, d[5:0]}, 32'h01);
    end
  endtask
  task forceOffAndPinSelect;
    begin
      host.setPin(1'b1, 1'b1);
      wrReg(`PSSC_ADDR_CTRL, 32'h51);
      repeat (10) @(posedge clk);
      #1 check({31'h0, inactive}, 32'h0);
      wrReg(`PSSC_ADDR_CTRL, 32'h41);
      repeat (10) @(posedge clk);
      #1 check({31'h0, inactive}, 32'h1);
      host.pulseReset;
      repeat (8) @(posedge clk);
      rdReg(`PSSC_ADDR_STAT, d);
      check({26'h0, d[5:0]}, 32'h20);
    end
  endtask
  task giveVerdict;
    begin
      if (nMismatch == 0 && testsRun > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 resetAndRegs;
    forceOnThenRelease;
    wakeByByte;
    forceOffAndPinSelect;
    giveVerdict;
  end
  // Run needs about 50200 cycles; this bound leaves ample margin
  initial
  begin
    repeat (75000) @(posedge clk);
    nMismatch = nMismatch + 1;
    giveVerdict;
  end
endmodule
